//--- verilog/ccs_pkg.sv
// Package for the clock and module standby controller: register map, fields, reset values, types.
// Assumes an 8-bit register port with byte addresses and one core clock at 100 MHz.
package ccs_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_EXT_PIN  = 8'h20;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h21;
  localparam logic [7:0] ADDR_SYS_CTRL = 8'h22;
  localparam logic [7:0] ADDR_SYS_DIV  = 8'h23;
  localparam logic [7:0] ADDR_CLK_STOP = 8'h24;
  localparam logic [7:0] ADDR_IRQ_PRI  = 8'h49;
  localparam logic [7:0] ADDR_MSTBY    = 8'h12;
  localparam logic [7:0] ADDR_PROTECT  = 8'h13;
  localparam logic [7:0] ADDR_MSTBY2   = 8'h17;

  // Bit positions and field layouts
  localparam int BIT_UNLOCK      = 0;
  localparam int BIT_SLOW_STOP   = 1;
  localparam int BIT_FAST_SEL    = 6;
  localparam int BIT_BASE_SEL    = 7;
  localparam int BIT_SERIAL0_SBY = 6;
  localparam int BIT_IR_SBY      = 0;
  localparam int RATIO_LSB       = 0;
  localparam int RATIO_W         = 3;
  localparam int PIN_FN_LSB      = 0;
  localparam int PIN_FN_W        = 2;
  localparam int IRQ_LVL_LSB     = 0;
  localparam int IRQ_LVL_W       = 2;
  localparam int CPU_CNT_W       = 7;

  localparam logic [PIN_FN_W-1:0]  PIN_FN_CRYSTAL = 2'h3;
  localparam logic [IRQ_LVL_W-1:0] IRQ_LVL_OFF    = 2'h0;
  localparam logic [RATIO_W-1:0]   RATIO_NONE     = 3'h0;

  // Reset values
  localparam logic [7:0] RST_EXT_PIN  = 8'h00;
  localparam logic [7:0] RST_OSC_CTRL = 8'h00;
  localparam logic [7:0] RST_SYS_CTRL = 8'h00;
  localparam logic [7:0] RST_SYS_DIV  = 8'h00;
  localparam logic [7:0] RST_CLK_STOP = 8'h00;
  localparam logic [7:0] RST_IRQ_PRI  = 8'h00;
  localparam logic [7:0] RST_MSTBY    = 8'h40;
  localparam logic [7:0] RST_PROTECT  = 8'h00;
  localparam logic [7:0] RST_MSTBY2   = 8'h01;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  localparam logic [7:0] ONE_BYTE     = 8'h01;
  localparam logic [CPU_CNT_W-1:0] ZERO_CPU_CNT = 7'h00;
  localparam logic [CPU_CNT_W-1:0] ONE_CPU_CNT  = 7'h01;

  // Base clock sources, one-hot
  typedef enum logic [2:0] {
    SRC_SLOW = 3'h1,
    SRC_XTAL = 3'h2,
    SRC_HOCO = 3'h4
  } ccs_src_type;

  // Source switch sequencer, one-hot
  typedef enum logic [2:0] {
    SW_RUN   = 3'h1,
    SW_DRAIN = 3'h2,
    SW_ARM   = 3'h4
  } ccs_sw_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccs_req_type;

  typedef struct packed {
    logic slow;
    logic xtal;
    logic hoco;
  } ccs_src_lvl_type;

endpackage

//--- verilog/ccs_clock_standby_ctrl.sv
// Clock source selection, base/system/CPU clock division, write protect and module standby control.
// Assumes oscillator levels and register strobes are synchronous to core_clk; clocks leave as
// sampled levels and one-cycle ticks of core_clk.
//
// Behaviour
// - Writes to clock registers are ignored unless the unlock bit is set.
// - System clock is base clock divided by divider value plus one; converter clock too.
// - CPU clock derives from system clock by 3-bit ratio; 000 passes it undivided.
// - Fast source select bit 6 at 0 picks crystal, at 1 the fast oscillator.
// - Base clock select bit 7 at 1 drives base clock from the fast clock.
// - Slow on-chip oscillator runs while its stop bit 1 is 0.
// - Pin function field 11 assigns shared pins to crystal input and output.
// - Serial channel 0 is active while its standby bit 6 is 0.
// - Infrared module is active while its standby bit 0 is 0.
// - Receive interrupt level field; 00 disables, 01 selects level 1.
`timescale 1ns/1ns

module ccs_clock_standby_ctrl (
  input  wire logic                        core_clk,        // Core clock, 100 MHz
  input  wire logic                        resetn,          // Asynchronous reset, active low
  input  wire ccs_pkg::ccs_req_type        bus_req,         // Register address, data and strobes
  input  wire ccs_pkg::ccs_src_lvl_type    src_lvl,         // Oscillator levels
  output logic [7:0]                       bus_rdata,       // Read data, cycle after read strobe
  output logic                             fast_clock,      // Selected fast clock level
  output logic                             base_clock,      // Base clock level
  output logic                             sys_clock_tick,  // System clock tick
  output logic                             converter_clock, // Converter clock tick
  output logic                             cpu_clock,       // CPU clock tick
  output logic                             slow_osc_run,    // Slow oscillator enable
  output logic                             crystal_input,   // Shared pin used as crystal input
  output logic                             crystal_output,  // Shared pin used as crystal output
  output logic                             serial0_active,  // Serial channel 0 clocked
  output logic                             infrared_active, // Infrared module clocked
  output logic [ccs_pkg::IRQ_LVL_W-1:0]    rx_irq_level,    // Receive interrupt priority
  output logic                             rx_irq_enable    // Receive interrupt allowed
);

  function automatic logic wr_hit(input ccs_pkg::ccs_req_type r, input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  function automatic logic src_level(input ccs_pkg::ccs_src_type s, input ccs_pkg::ccs_src_lvl_type l);
    unique case (s)
      ccs_pkg::SRC_SLOW: src_level = l.slow;
      ccs_pkg::SRC_XTAL: src_level = l.xtal;
      ccs_pkg::SRC_HOCO: src_level = l.hoco;
      default:           src_level = 1'b0;
    endcase
  endfunction

  function automatic logic [ccs_pkg::CPU_CNT_W-1:0] ratio_mask(input logic [ccs_pkg::RATIO_W-1:0] r);
    ratio_mask = ccs_pkg::CPU_CNT_W'((ccs_pkg::ONE_CPU_CNT << r) - ccs_pkg::ONE_CPU_CNT);
  endfunction

  // Registers
  logic [7:0] ext_pin_ff, osc_ctrl_ff, sys_ctrl_ff, sys_div_ff, clk_stop_ff;
  logic [7:0] irq_pri_ff, mstby_ff, protect_ff, mstby2_ff;
  logic [7:0] rdata_ff;

  // Clock path state
  ccs_pkg::ccs_src_type      active_src_ff;
  ccs_pkg::ccs_sw_state_type sw_state_ff;
  ccs_pkg::ccs_sw_state_type nxt_sw_state;
  ccs_pkg::ccs_src_type      nxt_active_src;
  logic [7:0]                div_cnt_ff, div_shadow_ff;
  logic [ccs_pkg::CPU_CNT_W-1:0] cpu_cnt_ff;
  logic [ccs_pkg::RATIO_W-1:0]   ratio_shadow_ff;
  logic fast_clk_ff, base_clk_ff, sys_tick_ff, adc_tick_ff, cpu_tick_ff;
  logic slow_run_ff, xin_ff, crystal_output_ff, serial_act_ff, ir_act_ff, irq_en_ff;
  logic [ccs_pkg::IRQ_LVL_W-1:0] irq_lvl_ff;

  // Write decode
  wire unlocked  = protect_ff[ccs_pkg::BIT_UNLOCK];
  wire we_ext    = wr_hit(bus_req, ccs_pkg::ADDR_EXT_PIN)  && unlocked;
  wire we_osc    = wr_hit(bus_req, ccs_pkg::ADDR_OSC_CTRL) && unlocked;
  wire we_sys    = wr_hit(bus_req, ccs_pkg::ADDR_SYS_CTRL) && unlocked;
  wire we_div    = wr_hit(bus_req, ccs_pkg::ADDR_SYS_DIV)  && unlocked;
  wire we_stop   = wr_hit(bus_req, ccs_pkg::ADDR_CLK_STOP) && unlocked;
  wire we_irq    = wr_hit(bus_req, ccs_pkg::ADDR_IRQ_PRI);
  wire we_mstby  = wr_hit(bus_req, ccs_pkg::ADDR_MSTBY);
  wire we_prot   = wr_hit(bus_req, ccs_pkg::ADDR_PROTECT);
  wire we_mstby2 = wr_hit(bus_req, ccs_pkg::ADDR_MSTBY2);

  // Read mux, unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    unique case (bus_req.addr)
      ccs_pkg::ADDR_EXT_PIN:  rd_mux = ext_pin_ff;
      ccs_pkg::ADDR_OSC_CTRL: rd_mux = osc_ctrl_ff;
      ccs_pkg::ADDR_SYS_CTRL: rd_mux = sys_ctrl_ff;
      ccs_pkg::ADDR_SYS_DIV:  rd_mux = sys_div_ff;
      ccs_pkg::ADDR_CLK_STOP: rd_mux = clk_stop_ff;
      ccs_pkg::ADDR_IRQ_PRI:  rd_mux = irq_pri_ff;
      ccs_pkg::ADDR_MSTBY:    rd_mux = mstby_ff;
      ccs_pkg::ADDR_PROTECT:  rd_mux = protect_ff;
      ccs_pkg::ADDR_MSTBY2:   rd_mux = mstby2_ff;
      default:                rd_mux = ccs_pkg::ZERO_BYTE;
    endcase
  end
  wire [7:0] nxt_rdata = bus_req.rd ? rd_mux : ccs_pkg::ZERO_BYTE;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ext_pin_ff  <= ccs_pkg::RST_EXT_PIN;
      osc_ctrl_ff <= ccs_pkg::RST_OSC_CTRL;
      sys_ctrl_ff <= ccs_pkg::RST_SYS_CTRL;
      sys_div_ff  <= ccs_pkg::RST_SYS_DIV;
      clk_stop_ff <= ccs_pkg::RST_CLK_STOP;
      irq_pri_ff  <= ccs_pkg::RST_IRQ_PRI;
      mstby_ff    <= ccs_pkg::RST_MSTBY;
      protect_ff  <= ccs_pkg::RST_PROTECT;
      mstby2_ff   <= ccs_pkg::RST_MSTBY2;
      rdata_ff    <= ccs_pkg::ZERO_BYTE;
    end else begin
      if (we_ext)    ext_pin_ff  <= bus_req.wdata;
      if (we_osc)    osc_ctrl_ff <= bus_req.wdata;
      if (we_sys)    sys_ctrl_ff <= bus_req.wdata;
      if (we_div)    sys_div_ff  <= bus_req.wdata;
      if (we_stop)   clk_stop_ff <= bus_req.wdata;
      if (we_irq)    irq_pri_ff  <= bus_req.wdata;
      if (we_mstby)  mstby_ff    <= bus_req.wdata;
      if (we_prot)   protect_ff  <= bus_req.wdata;
      if (we_mstby2) mstby2_ff   <= bus_req.wdata;
      rdata_ff <= nxt_rdata;
    end
  end

  // Requested base source
  wire slow_stop = osc_ctrl_ff[ccs_pkg::BIT_SLOW_STOP];
  wire fast_sel  = sys_ctrl_ff[ccs_pkg::BIT_FAST_SEL];
  wire base_sel  = clk_stop_ff[ccs_pkg::BIT_BASE_SEL];
  wire ccs_pkg::ccs_src_lvl_type lvl_gated = '{slow: src_lvl.slow & ~slow_stop,
                                               xtal: src_lvl.xtal,
                                               hoco: src_lvl.hoco};
  wire ccs_pkg::ccs_src_type fast_src = fast_sel ? ccs_pkg::SRC_HOCO : ccs_pkg::SRC_XTAL;
  wire ccs_pkg::ccs_src_type req_src  = base_sel ? fast_src : ccs_pkg::SRC_SLOW;
  wire old_lvl = src_level(active_src_ff, lvl_gated);
  wire new_lvl = src_level(req_src, lvl_gated);

  // Switch once old has gone low and while new is low, holding base low between them
  always_comb begin
    nxt_sw_state   = sw_state_ff;
    nxt_active_src = active_src_ff;
    unique case (sw_state_ff)
      ccs_pkg::SW_RUN: begin
        if (req_src != active_src_ff) nxt_sw_state = ccs_pkg::SW_DRAIN;
      end
      ccs_pkg::SW_DRAIN: begin
        if (req_src == active_src_ff) nxt_sw_state = ccs_pkg::SW_RUN;
        else if (!old_lvl) nxt_sw_state = ccs_pkg::SW_ARM;
      end
      ccs_pkg::SW_ARM: begin
        if (!new_lvl) begin
          nxt_sw_state   = ccs_pkg::SW_RUN;
          nxt_active_src = req_src;
        end
      end
      default: nxt_sw_state = ccs_pkg::SW_RUN;
    endcase
  end

  wire base_now  = (sw_state_ff != ccs_pkg::SW_ARM) && old_lvl;
  wire base_rise = base_now && !base_clk_ff;

  // System divider reloads only at wrap, so no period is cut short
  wire div_wrap     = base_rise && (div_cnt_ff == div_shadow_ff);
  wire [7:0] nxt_div_cnt = div_wrap ? ccs_pkg::ZERO_BYTE :
                           base_rise ? 8'(div_cnt_ff + ccs_pkg::ONE_BYTE) : div_cnt_ff;
  wire [7:0] nxt_div_shadow = div_wrap ? sys_div_ff : div_shadow_ff;

  // CPU divider by power of two, ratio applied at its own wrap
  wire [ccs_pkg::CPU_CNT_W-1:0] cpu_mask = ratio_mask(ratio_shadow_ff);
  wire cpu_wrap = div_wrap && ((cpu_cnt_ff & cpu_mask) == cpu_mask);
  wire [ccs_pkg::CPU_CNT_W-1:0] nxt_cpu_cnt = cpu_wrap ? ccs_pkg::ZERO_CPU_CNT :
      div_wrap ? ccs_pkg::CPU_CNT_W'(cpu_cnt_ff + ccs_pkg::ONE_CPU_CNT) : cpu_cnt_ff;
  wire [ccs_pkg::RATIO_W-1:0] nxt_ratio = cpu_wrap ?
      sys_ctrl_ff[ccs_pkg::RATIO_LSB +: ccs_pkg::RATIO_W] : ratio_shadow_ff;

  wire nxt_fast_clk = src_level(fast_src, lvl_gated);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sw_state_ff     <= ccs_pkg::SW_RUN;
      active_src_ff   <= ccs_pkg::SRC_SLOW;
      base_clk_ff     <= 1'b0;
      fast_clk_ff     <= 1'b0;
      div_cnt_ff      <= ccs_pkg::ZERO_BYTE;
      div_shadow_ff   <= ccs_pkg::RST_SYS_DIV;
      cpu_cnt_ff      <= ccs_pkg::ZERO_CPU_CNT;
      ratio_shadow_ff <= ccs_pkg::RATIO_NONE;
      sys_tick_ff     <= 1'b0;
      adc_tick_ff     <= 1'b0;
      cpu_tick_ff     <= 1'b0;
    end else begin
      sw_state_ff     <= nxt_sw_state;
      active_src_ff   <= nxt_active_src;
      base_clk_ff     <= base_now;
      fast_clk_ff     <= nxt_fast_clk;
      div_cnt_ff      <= nxt_div_cnt;
      div_shadow_ff   <= nxt_div_shadow;
      cpu_cnt_ff      <= nxt_cpu_cnt;
      ratio_shadow_ff <= nxt_ratio;
      sys_tick_ff     <= div_wrap;
      adc_tick_ff     <= div_wrap;
      cpu_tick_ff     <= cpu_wrap;
    end
  end

  // Pin, standby and interrupt outputs
  wire [ccs_pkg::PIN_FN_W-1:0]  pin_fn  = ext_pin_ff[ccs_pkg::PIN_FN_LSB +: ccs_pkg::PIN_FN_W];
  wire [ccs_pkg::IRQ_LVL_W-1:0] irq_lvl = irq_pri_ff[ccs_pkg::IRQ_LVL_LSB +: ccs_pkg::IRQ_LVL_W];
  wire nxt_xtal_pins = (pin_fn == ccs_pkg::PIN_FN_CRYSTAL);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      slow_run_ff   <= 1'b0;
      xin_ff        <= 1'b0;
      crystal_output_ff       <= 1'b0;
      serial_act_ff <= 1'b0;
      ir_act_ff     <= 1'b0;
      irq_lvl_ff    <= ccs_pkg::IRQ_LVL_OFF;
      irq_en_ff     <= 1'b0;
    end else begin
      slow_run_ff   <= !slow_stop;
      xin_ff        <= nxt_xtal_pins;
      crystal_output_ff       <= nxt_xtal_pins;
      serial_act_ff <= !mstby_ff[ccs_pkg::BIT_SERIAL0_SBY];
      ir_act_ff     <= !mstby2_ff[ccs_pkg::BIT_IR_SBY];
      irq_lvl_ff    <= irq_lvl;
      irq_en_ff     <= (irq_lvl != ccs_pkg::IRQ_LVL_OFF);
    end
  end

  assign bus_rdata       = rdata_ff;
  assign fast_clock      = fast_clk_ff;
  assign base_clock      = base_clk_ff;
  assign sys_clock_tick  = sys_tick_ff;
  assign converter_clock = adc_tick_ff;
  assign cpu_clock       = cpu_tick_ff;
  assign slow_osc_run    = slow_run_ff;
  assign crystal_input   = xin_ff;
  assign crystal_output  = crystal_output_ff;
  assign serial0_active  = serial_act_ff;
  assign infrared_active = ir_act_ff;
  assign rx_irq_level    = irq_lvl_ff;
  assign rx_irq_enable   = irq_en_ff;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Remembers whether the last system tick also carried a CPU tick
  logic tick_was_cpu_ff;
  wire  nxt_tick_was_cpu = sys_tick_ff ? cpu_tick_ff : tick_was_cpu_ff;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tick_was_cpu_ff <= 1'b0;
    end else begin
      tick_was_cpu_ff <= nxt_tick_was_cpu;
    end
  end

  a_locked_div_write: assert property (
    wr_hit(bus_req, ccs_pkg::ADDR_SYS_DIV) && !protect_ff[ccs_pkg::BIT_UNLOCK] |=> $stable(sys_div_ff))
    else $error("Divider changed while write protected");

  a_unlocked_div_write: assert property (
    wr_hit(bus_req, ccs_pkg::ADDR_SYS_DIV) && protect_ff[ccs_pkg::BIT_UNLOCK] |=> sys_div_ff == $past(bus_req.wdata))
    else $error("Divider write lost while unlocked");

  a_sys_tick_count: assert property (
    sys_tick_ff |-> div_cnt_ff == ccs_pkg::ZERO_BYTE && $past(div_cnt_ff) == $past(div_shadow_ff)
                    && $past(base_now) && !$past(base_clk_ff))
    else $error("System tick not at divider wrap");

  a_converter_equal: assert property (
    converter_clock == sys_clock_tick)
    else $error("Converter clock differs from system clock");

  a_cpu_passthru: assert property (
    $past(ratio_shadow_ff) == ccs_pkg::RATIO_NONE |-> cpu_tick_ff == sys_tick_ff)
    else $error("CPU clock not equal to system clock at ratio zero");

  a_cpu_half: assert property (
    sys_tick_ff && tick_was_cpu_ff && $past(ratio_shadow_ff) == 3'h1 |-> !cpu_tick_ff)
    else $error("CPU clock not halved");

  a_source_match: assert property (
    sw_state_ff == ccs_pkg::SW_RUN && $stable(sys_ctrl_ff) && $stable(clk_stop_ff)
      |-> active_src_ff == (clk_stop_ff[ccs_pkg::BIT_BASE_SEL] ?
            (sys_ctrl_ff[ccs_pkg::BIT_FAST_SEL] ? ccs_pkg::SRC_HOCO : ccs_pkg::SRC_XTAL) : ccs_pkg::SRC_SLOW))
    else $error("Active source does not match selection");

  a_base_from_fast: assert property (
    sw_state_ff == ccs_pkg::SW_RUN && clk_stop_ff[ccs_pkg::BIT_BASE_SEL] && active_src_ff == fast_src
      |=> base_clock == fast_clock)
    else $error("Base clock not following fast clock");

  a_slow_osc_run: assert property (
    $past(resetn) |-> slow_osc_run == !$past(osc_ctrl_ff[ccs_pkg::BIT_SLOW_STOP]))
    else $error("Slow oscillator enable wrong");

  a_crystal_pins: assert property (
    crystal_input == ($past(ext_pin_ff[1:0]) == ccs_pkg::PIN_FN_CRYSTAL) && crystal_output == crystal_input)
    else $error("Crystal pin function wrong");

  a_serial_active: assert property (
    serial0_active == !$past(mstby_ff[ccs_pkg::BIT_SERIAL0_SBY]))
    else $error("Serial channel activity wrong");

  a_infrared_active: assert property (
    infrared_active == !$past(mstby2_ff[ccs_pkg::BIT_IR_SBY]))
    else $error("Infrared activity wrong");

  a_irq_level: assert property (
    rx_irq_enable == (rx_irq_level != ccs_pkg::IRQ_LVL_OFF) && rx_irq_level == $past(irq_pri_ff[1:0]))
    else $error("Receive interrupt level wrong");

  a_switch_glitch: assert property (
    $changed(active_src_ff) |-> $past(sw_state_ff) == ccs_pkg::SW_ARM && !base_clk_ff && !$past(new_lvl))
    else $error("Source switched outside a low gap");

  a_read_idle: assert property (
    !$past(bus_req.rd) |-> bus_rdata == ccs_pkg::ZERO_BYTE)
    else $error("Read data without read strobe");

  a_fast_xtal: assert property (
    $past(resetn) && !sys_ctrl_ff[ccs_pkg::BIT_FAST_SEL] |=> fast_clock == $past(src_lvl.xtal))
    else $error("Fast clock not taken from crystal");

  a_base_low_arm: assert property (
    sw_state_ff == ccs_pkg::SW_ARM |=> !base_clock)
    else $error("Base clock high during source switch");

  a_read_protect: assert property (
    bus_req.rd && bus_req.addr == ccs_pkg::ADDR_PROTECT |=> bus_rdata == $past(protect_ff))
    else $error("Protect register read back wrong");

  c_source_switch: cover property ($changed(active_src_ff));
  c_cpu_divided:   cover property (cpu_tick_ff && ratio_shadow_ff != ccs_pkg::RATIO_NONE);
  c_locked_write:  cover property (wr_hit(bus_req, ccs_pkg::ADDR_SYS_CTRL) && !protect_ff[ccs_pkg::BIT_UNLOCK]);
  c_divider_wrap:  cover property (sys_tick_ff && div_shadow_ff != ccs_pkg::ZERO_BYTE);
  c_base_on_fast:  cover property (base_rise && active_src_ff == ccs_pkg::SRC_HOCO);

endmodule

//--- test/ccs_clock_standby_ctrl_tb.sv
// Self-checking bench for the clock and module standby controller: register access, protect, standby,
// interrupt level, pin function and clock division and selection, all driven through the register port.
// Assumes the design package is compiled first; the oscillator levels are made here from a free counter.
`timescale 1ns/1ns

module ccs_clock_standby_ctrl_tb;
  logic                 core_clk = 1'b0;
  logic                 resetn   = 1'b0;
  ccs_pkg::ccs_req_type bus_req  = '0;
  ccs_pkg::ccs_src_lvl_type src_lvl = '0;
  logic [7:0]           src_cnt  = 8'h00;
  logic [7:0]           bus_rdata;
  logic                 fast_clock;
  logic                 base_clock;
  logic                 sys_clock_tick;
  logic                 converter_clock;
  logic                 cpu_clock;
  logic                 slow_osc_run;
  logic                 crystal_input;
  logic                 crystal_output;
  logic                 serial0_active;
  logic                 infrared_active;
  logic [1:0]           rx_irq_level;
  logic                 rx_irq_enable;
  int                   bad_count  = 0;
  int                   n_compared = 0;
  logic [7:0]           rd_val;
  logic [7:0]           addr_tab [9] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h49, 8'h12, 8'h13, 8'h17};
  logic [7:0]           rst_tab  [9] = '{ccs_pkg::RST_EXT_PIN, ccs_pkg::RST_OSC_CTRL, ccs_pkg::RST_SYS_CTRL,
                                        ccs_pkg::RST_SYS_DIV, ccs_pkg::RST_CLK_STOP, ccs_pkg::RST_IRQ_PRI,
                                        ccs_pkg::RST_MSTBY, ccs_pkg::RST_PROTECT, ccs_pkg::RST_MSTBY2};

  always #5 core_clk = ~core_clk;

  // Slow source toggles each cycle, crystal every 2 cycles, fast oscillator every 4 cycles
  always @(posedge core_clk) begin
    src_cnt <= src_cnt + 8'h01;
    src_lvl <= {src_cnt[0], src_cnt[1], src_cnt[2]};
  end

  ccs_clock_standby_ctrl i_ccs_clock_standby_ctrl (
    .core_clk        (core_clk),
    .resetn          (resetn),
    .bus_req         (bus_req),
    .src_lvl         (src_lvl),
    .bus_rdata       (bus_rdata),
    .fast_clock      (fast_clock),
    .base_clock      (base_clock),
    .sys_clock_tick  (sys_clock_tick),
    .converter_clock (converter_clock),
    .cpu_clock       (cpu_clock),
    .slow_osc_run    (slow_osc_run),
    .crystal_input   (crystal_input),
    .crystal_output  (crystal_output),
    .serial0_active  (serial0_active),
    .infrared_active (infrared_active),
    .rx_irq_level    (rx_irq_level),
    .rx_irq_enable   (rx_irq_enable)
  );

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Compared %0d values, %0d mismatches", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
  endtask

  // Read data stand in the cycle after the edge that takes the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
    d = bus_rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0:       return sys_clock_tick;
      1:       return cpu_clock;
      2:       return fast_clock;
      default: return base_clock;
    endcase
  endfunction

  // Aligns to a rise of the chosen signal, then counts rises over k periods
  task automatic measure(input string name, input int sel, input int period, input int k);
    int   cnt;
    int   wait_n;
    logic prev;
    logic s;
    logic conv_ok;
    cnt = 0;
    wait_n = 0;
    conv_ok = 1'b1;
    prev = pick(sel);
    settle(1);
    while (!(pick(sel) === 1'b1 && prev === 1'b0) && wait_n < 4 * period + 200) begin
      prev = pick(sel);
      wait_n++;
      settle(1);
    end
    prev = pick(sel);
    repeat (period * k) begin
      settle(1);
      s = pick(sel);
      if (s === 1'b1 && prev === 1'b0) cnt++;
      if (converter_clock !== sys_clock_tick) conv_ok = 1'b0;
      prev = s;
    end
    check(name, cnt[7:0], k[7:0]);
    check("converter_clock", {7'h00, conv_ok}, 8'h01);
  endtask

  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    settle(2);
    check("slow_osc_run", slow_osc_run, 8'h01);
    check("serial0_active", serial0_active, 8'h00);
    check("infrared_active", infrared_active, 8'h00);
    check("rx_irq_enable", rx_irq_enable, 8'h00);
    for (int i = 0; i < 9; i++) begin
      rd_reg(addr_tab[i], rd_val);
      check("reset value", rd_val, rst_tab[i]);
    end
    rd_reg(8'h30, rd_val);
    check("unmapped read", rd_val, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 5; i++) wr_reg(addr_tab[i], 8'hC3);
    for (int i = 0; i < 5; i++) begin
      rd_reg(addr_tab[i], rd_val);
      check("locked write", rd_val, rst_tab[i]);
    end
    wr_reg(ccs_pkg::ADDR_PROTECT, 8'h01);
    wr_reg(ccs_pkg::ADDR_EXT_PIN, 8'h03);
    rd_reg(ccs_pkg::ADDR_EXT_PIN, rd_val);
    check("unlocked write", rd_val, 8'h03);
    check("crystal_input", crystal_input, 8'h01);
    check("crystal_output", crystal_output, 8'h01);
    wr_reg(ccs_pkg::ADDR_EXT_PIN, 8'h01);
    settle(2);
    check("crystal_input", crystal_input, 8'h00);
    check("crystal_output", crystal_output, 8'h00);
    $display("test protect and pins done");
    wr_reg(ccs_pkg::ADDR_OSC_CTRL, 8'h02);
    settle(2);
    check("slow_osc_run", slow_osc_run, 8'h00);
    wr_reg(ccs_pkg::ADDR_OSC_CTRL, 8'h00);
    wr_reg(ccs_pkg::ADDR_MSTBY, 8'h00);
    wr_reg(ccs_pkg::ADDR_MSTBY2, 8'h00);
    settle(2);
    check("slow_osc_run", slow_osc_run, 8'h01);
    check("serial0_active", serial0_active, 8'h01);
    check("infrared_active", infrared_active, 8'h01);
    wr_reg(ccs_pkg::ADDR_MSTBY, 8'h40);
    wr_reg(ccs_pkg::ADDR_MSTBY2, 8'h01);
    settle(2);
    check("serial0_active", serial0_active, 8'h00);
    check("infrared_active", infrared_active, 8'h00);
    for (int l = 0; l < 4; l++) begin
      wr_reg(ccs_pkg::ADDR_IRQ_PRI, l[7:0]);
      settle(2);
      check("rx_irq_level", {6'h00, rx_irq_level}, l[7:0]);
      check("rx_irq_enable", rx_irq_enable, (l != 0) ? 8'h01 : 8'h00);
    end
    $display("test standby and irq done");
    foreach (rst_tab[n]) if (n < 3) begin
      wr_reg(ccs_pkg::ADDR_SYS_DIV, (8'h01 << n) - 8'h01);
      settle(64);
      measure("sys_clock_tick", 0, 2 << n, 4);
    end
    for (int r = 0; r < 3; r++) begin
      wr_reg(ccs_pkg::ADDR_SYS_CTRL, r[7:0]);
      settle(64);
      measure("cpu_clock", 1, 8 << r, 3);
    end
    $display("test division done");
    wr_reg(ccs_pkg::ADDR_SYS_CTRL, 8'h00);
    settle(8);
    measure("fast_clock xtal", 2, 4, 4);
    wr_reg(ccs_pkg::ADDR_SYS_CTRL, 8'h40);
    settle(8);
    measure("fast_clock hoco", 2, 8, 4);
    wr_reg(ccs_pkg::ADDR_CLK_STOP, 8'h80);
    settle(64);
    measure("base_clock", 3, 8, 4);
    measure("sys_clock_tick", 0, 32, 2);
    wr_reg(ccs_pkg::ADDR_CLK_STOP, 8'h00);
    settle(64);
    measure("base_clock", 3, 2, 4);
    $display("test source select done");
    wr_reg(ccs_pkg::ADDR_PROTECT, 8'h00);
    wr_reg(ccs_pkg::ADDR_SYS_DIV, 8'h07);
    rd_reg(ccs_pkg::ADDR_SYS_DIV, rd_val);
    check("relocked write", rd_val, 8'h03);
    $display("test relock done");
    stop_test();
  end
endmodule
